/* File: include/isc_pkg.sv */
// ==========================================================
// i2c slave stretch and address control: shared definitions
// ==========================================================
package isc_pkg;

    // ======================================================
    // register map, word indices on the plain register port
    // ======================================================
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_OWN_ADDR = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam int REG_WIDTH = 16;

    // ======================================================
    // control register, low four bits
    // ======================================================
    typedef struct packed {
        logic wideAddressMode;   // 1: ten-bit own address
        logic acceptAllAddr;     // 1: every address acknowledged
        logic stretchEnable;     // 1: release bit fully writable
        logic clockLineRelease;  // 0: hold clock low, 1: let go
    } isc_ctrl_t;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // ======================================================
    // status register, low six bits
    // ======================================================
    typedef struct packed {
        logic clockHeld;      // block is pulling the clock line low
        logic tenMatched;     // ten-bit address fully matched
        logic masterNack;     // last transmitted byte not acknowledged
        logic transmitting;   // slave transmit in progress
        logic slaveActive;    // addressed by the bus master
        logic rxFull;         // received byte waiting in data register
    } isc_status_t;

    // ======================================================
    // reset values and bus constants
    // ======================================================
    localparam logic [9:0] OWN_ADDR_RESET = 10'h000;
    localparam logic [7:0] TX_DATA_RESET = 8'hff;
    localparam logic [4:0] TEN_HDR_CODE = 5'h1e;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BITS_ACK = 4'h8;
    localparam logic [3:0] BITS_END = 4'h9;

    // ======================================================
    // slave sequencer states
    // ======================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR2,
        ST_ADDRACK,
        ST_RX,
        ST_RXACK,
        ST_TX,
        ST_TXACK
    } isc_state_t;

endpackage : isc_pkg

/* File: logic/isc_slave_ctl.sv */
`timescale 1ns/1ns
// ==========================================================
// i2c slave port: clock stretch and own-address control
// ==========================================================
// Contract
// - stretch enabled: release bit writable, zero holds clock, one releases it.
// - stretch enabled: hardware clears release bit after each received byte.
// - stretch disabled: software may only set release bit; zero writes ignored.
// - hardware always clears release bit when a slave transmission begins.
// - accept-all enabled: acknowledge every address; otherwise normal matching.
// - wide address mode one: match ten-bit own address; zero: seven-bit.
// - release bit zero drives clock line low while the slave is addressed; one lets it go.
module isc_slave_ctl
    import isc_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [REG_WIDTH-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [REG_WIDTH-1:0] regRdData,
    // serial clock pin and link clock
    input wire logic sclClk,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOeN,
    // serial data pin
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN
);

    // ======================================================
    // link domain: bit capture on serial clock rise
    // ======================================================
    logic [7:0] linkShiftQ;

    // shifts in one data bit per rising clock edge, no reset needed
    always_ff @(posedge sclClk) begin
        linkShiftQ <= {linkShiftQ[6:0], sdaIn};
    end

    // ======================================================
    // pin synchronisers and bus event detection
    // ======================================================
    logic sclMetaQ, sclSyncQ, sclPrevQ;
    logic sdaMetaQ, sdaSyncQ, sdaPrevQ;

    // two flops per pin, then one more for edge detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclMetaQ <= 1'b1;
            sclSyncQ <= 1'b1;
            sclPrevQ <= 1'b1;
            sdaMetaQ <= 1'b1;
            sdaSyncQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end else if (clkEn) begin
            sclMetaQ <= sclIn;
            sclSyncQ <= sclMetaQ;
            sclPrevQ <= sclSyncQ;
            sdaMetaQ <= sdaIn;
            sdaSyncQ <= sdaMetaQ;
            sdaPrevQ <= sdaSyncQ;
        end
    end

    // start and stop are data edges while the clock stays high
    wire sclRise = sclSyncQ & ~sclPrevQ;
    wire sclFall = ~sclSyncQ & sclPrevQ;
    wire startSeen = sclSyncQ & sclPrevQ & sdaPrevQ & ~sdaSyncQ;
    wire stopSeen = sclSyncQ & sclPrevQ & ~sdaPrevQ & sdaSyncQ;

    // ======================================================
    // register state
    // ======================================================
    isc_ctrl_t ctrlQ, ctrlD;
    logic [9:0] ownAddrQ;
    logic [7:0] txDataQ;
    logic [7:0] rxDataQ;
    logic rxFullQ, rxFullD;
    logic [REG_WIDTH-1:0] rdDataQ;
    logic sclOutQ, sdaOutQ;

    // ======================================================
    // sequencer state
    // ======================================================
    isc_state_t stateQ, stateD;
    isc_state_t nextQ, nextD;
    logic [3:0] bitCntQ, bitCntD;
    logic [7:0] gotByteQ;
    logic [7:0] txShiftQ, txShiftD;
    logic sdaOeNQ, sdaDriveD;
    logic sclOeNQ, sclDriveD;
    logic tenMatchQ, tenMatchD;
    logic nackQ, nackD;
    logic rxPulse, txBegin, rxEnd;

    // ======================================================
    // register port decode
    // ======================================================
    wire wrCtrl = regWr & (regAddr == REG_CTRL);
    wire wrOwnAddr = regWr & (regAddr == REG_OWN_ADDR);
    wire wrData = regWr & (regAddr == REG_DATA);
    wire rdData = regRd & (regAddr == REG_DATA);
    wire isc_ctrl_t ctrlWrVal = isc_ctrl_t'(regWrData[3:0]);

    // ======================================================
    // address match decode on the last byte taken
    // ======================================================
    wire rwBit = gotByteQ[0];
    wire isTenHdr = gotByteQ[7:3] == TEN_HDR_CODE;
    wire hit7 = ~ctrlQ.wideAddressMode & (gotByteQ[7:1] == ownAddrQ[6:0]);
    wire hitHdr = ctrlQ.wideAddressMode & isTenHdr
        & (gotByteQ[2:1] == ownAddrQ[9:8]);
    wire hitLow = gotByteQ == ownAddrQ[7:0];
    // read header only counts after the full ten-bit write match
    wire addrAck = ctrlQ.acceptAllAddr | hit7
        | (hitHdr & (~rwBit | tenMatchQ));
    wire isc_state_t addrNext = rwBit ? ST_TX
        : ((hitHdr & ~ctrlQ.acceptAllAddr) ? ST_ADDR2 : ST_RX);

    // ======================================================
    // status and read selection
    // ======================================================
    wire sclHeld = ~sclOeNQ;
    wire slaveActive = (stateQ != ST_IDLE) & (stateQ != ST_ADDR) & (stateQ != ST_ADDR2);
    wire transmitting = (stateQ == ST_TX) | (stateQ == ST_TXACK);
    wire isc_status_t statusVal = '{clockHeld: sclHeld, tenMatched: tenMatchQ,
        masterNack: nackQ, transmitting: transmitting,
        slaveActive: slaveActive, rxFull: rxFullQ};
    wire [REG_WIDTH-1:0] rdMux =
        (regAddr == REG_CTRL) ? {12'h000, ctrlQ} :
        (regAddr == REG_OWN_ADDR) ? {6'h00, ownAddrQ} :
        (regAddr == REG_DATA) ? {8'h00, rxDataQ} :
        {10'h000, statusVal};

    // ======================================================
    // sequencer next state
    // ======================================================
    always_comb begin
        stateD = stateQ;
        nextD = nextQ;
        bitCntD = bitCntQ;
        txShiftD = txShiftQ;
        sdaDriveD = ~sdaOeNQ;
        tenMatchD = tenMatchQ;
        nackD = nackQ;
        rxPulse = 1'b0;
        txBegin = 1'b0;
        rxEnd = 1'b0;
        if (stopSeen) begin
            // stop ends everything and frees the data line
            stateD = ST_IDLE;
            bitCntD = 4'h0;
            sdaDriveD = 1'b0;
            tenMatchD = 1'b0;
        end else if (startSeen) begin
            // start or repeated start: keep the ten-bit match
            stateD = ST_ADDR;
            bitCntD = 4'h0;
            sdaDriveD = 1'b0;
        end else begin
            if (sclRise && stateQ != ST_IDLE && bitCntQ != BITS_END) begin
                bitCntD = bitCntQ + 4'h1;
            end
            if (sclRise && stateQ == ST_TXACK) begin
                nackD = sdaSyncQ;
            end
            if (sclFall && stateQ != ST_IDLE) begin
                if (bitCntQ == BITS_ACK) begin
                    // eight bits done: acknowledge or hand over
                    case (stateQ)
                        ST_ADDR: begin
                            if (addrAck) begin
                                sdaDriveD = 1'b1;
                                stateD = ST_ADDRACK;
                                nextD = addrNext;
                            end else begin
                                stateD = ST_IDLE;
                            end
                        end
                        ST_ADDR2: begin
                            if (hitLow) begin
                                sdaDriveD = 1'b1;
                                stateD = ST_ADDRACK;
                                nextD = ST_RX;
                                tenMatchD = 1'b1;
                            end else begin
                                stateD = ST_IDLE;
                            end
                        end
                        ST_RX: begin
                            sdaDriveD = 1'b1;
                            rxPulse = 1'b1;
                            stateD = ST_RXACK;
                        end
                        ST_TX: begin
                            sdaDriveD = 1'b0;
                            stateD = ST_TXACK;
                        end
                        default: begin
                        end
                    endcase
                end else if (bitCntQ == BITS_END) begin
                    // ninth clock done: start next byte
                    bitCntD = 4'h0;
                    sdaDriveD = 1'b0;
                    case (stateQ)
                        ST_ADDRACK: begin
                            stateD = nextQ;
                            if (nextQ == ST_TX) begin
                                txBegin = 1'b1;
                                sdaDriveD = ~txDataQ[7];
                                txShiftD = {txDataQ[6:0], 1'b0};
                            end
                        end
                        ST_RXACK: begin
                            stateD = ST_RX;
                            rxEnd = 1'b1;
                        end
                        ST_TXACK: begin
                            if (!nackQ) begin
                                stateD = ST_TX;
                                txBegin = 1'b1;
                                sdaDriveD = ~txDataQ[7];
                                txShiftD = {txDataQ[6:0], 1'b0};
                            end else begin
                                stateD = ST_IDLE;
                            end
                        end
                        default: begin
                            stateD = ST_IDLE;
                        end
                    endcase
                end else if (stateQ == ST_TX) begin
                    // shift out the next data bit, msb first
                    sdaDriveD = ~txShiftQ[7];
                    txShiftD = {txShiftQ[6:0], 1'b0};
                end
            end
        end
    end

    // ======================================================
    // release bit and register next values
    // ======================================================
    always_comb begin
        ctrlD = ctrlQ;
        if (txBegin || (rxEnd && ctrlQ.stretchEnable)) begin
            ctrlD.clockLineRelease = 1'b0;
        end
        if (wrCtrl) begin
            ctrlD.wideAddressMode = ctrlWrVal.wideAddressMode;
            ctrlD.acceptAllAddr = ctrlWrVal.acceptAllAddr;
            ctrlD.stretchEnable = ctrlWrVal.stretchEnable;
            if (ctrlQ.stretchEnable) begin
                ctrlD.clockLineRelease = ctrlWrVal.clockLineRelease;
            end else begin
                ctrlD.clockLineRelease = ctrlD.clockLineRelease
                    | ctrlWrVal.clockLineRelease;
            end
        end
    end

    // received byte flag: a new byte wins over a read
    assign rxFullD = rxPulse | (rxFullQ & ~rdData);

    // hold only once the clock is already low, never cut a high phase
    assign sclDriveD = ~ctrlQ.clockLineRelease & slaveActive
        & (~sclSyncQ | sclHeld);

    // ======================================================
    // byte capture from the link domain
    // ======================================================
    // link shift stays still for microseconds after each rise,
    // so it is taken on the synchronised edge, a few cycles after the rise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gotByteQ <= 8'h00;
        end else if (clkEn && sclRise && bitCntQ == BIT_LAST_DATA) begin
            gotByteQ <= linkShiftQ;
        end
    end

    // ======================================================
    // sequencer registers
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stateQ <= ST_IDLE;
            nextQ <= ST_IDLE;
            bitCntQ <= 4'h0;
            txShiftQ <= 8'h00;
            tenMatchQ <= 1'b0;
            nackQ <= 1'b0;
        end else if (clkEn) begin
            stateQ <= stateD;
            nextQ <= nextD;
            bitCntQ <= bitCntD;
            txShiftQ <= txShiftD;
            tenMatchQ <= tenMatchD;
            nackQ <= nackD;
        end
    end

    // ======================================================
    // pin drivers, enables low while pulling the line
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sdaOeNQ <= 1'b1;
            sclOeNQ <= 1'b1;
            sdaOutQ <= 1'b0;
            sclOutQ <= 1'b0;
        end else if (clkEn) begin
            sdaOeNQ <= ~sdaDriveD;
            sclOeNQ <= ~sclDriveD;
        end
    end

    // ======================================================
    // software registers
    // ======================================================
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrlQ <= isc_ctrl_t'(CTRL_RESET);
            ownAddrQ <= OWN_ADDR_RESET;
            txDataQ <= TX_DATA_RESET;
            rxDataQ <= 8'h00;
            rxFullQ <= 1'b0;
        end else if (clkEn) begin
            ctrlQ <= ctrlD;
            rxFullQ <= rxFullD;
            if (wrOwnAddr) begin
                ownAddrQ <= regWrData[9:0];
            end
            if (wrData) begin
                txDataQ <= regWrData[7:0];
            end
            if (rxPulse) begin
                rxDataQ <= gotByteQ;
            end
        end
    end

    // read data stand for one cycle only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdDataQ <= '0;
        end else if (clkEn) begin
            rdDataQ <= regRd ? rdMux : '0;
        end
    end

    // ======================================================
    // outputs
    // ======================================================
    assign regRdData = rdDataQ;
    assign sclOut = sclOutQ;
    assign sclOeN = sclOeNQ;
    assign sdaOut = sdaOutQ;
    assign sdaOeN = sdaOeNQ;

endmodule : isc_slave_ctl

/* File: testbench/isc_slave_ctl_assertions.sv */
`timescale 1ns/1ns
// ====
// port checker for the slave control block
module isc_slave_ctl_assertions
    import isc_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [REG_WIDTH-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [REG_WIDTH-1:0] regRdData,
    // serial pins
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOeN,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOeN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // control writes, release writes
    wire ctrlWr = regWr && regAddr == REG_CTRL;
    wire relWr = ctrlWr && regWrData[0];
    // write, then a control read two cycles on
    sequence ctrl_wr_rd;
        ctrlWr ##2 (regRd && regAddr == REG_CTRL);
    endsequence
    sequence rel_wr_rd;
        relWr ##2 (regRd && regAddr == REG_CTRL);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |=> sclOeN && sdaOeN && regRdData == 16'h0000)
        else $error("pins or read data active after reset");
    a_idle_read_zero: assert property (!regRd |=> regRdData == 16'h0000)
        else $error("read data outside read answer cycle");
    a_pins_drive_low: assert property (!sclOut && !sdaOut)
        else $error("pin drive value not low");
    a_release_frees_clock: assert property (relWr |=> ##[0:3] sclOeN)
        else $error("clock still held after release write");
    a_hold_stays: assert property (
        !sclOeN && !relWr && !$past(relWr) && !$past(relWr, 2) && !$past(relWr, 3)
        |=> !sclOeN)
        else $error("clock hold dropped without release");
    a_ctrl_fields_kept: assert property (
        ctrl_wr_rd |=> regRdData[3:1] == $past(regWrData[3:1], 3))
        else $error("control fields not as written");
    a_release_set_only: assert property (rel_wr_rd |=> regRdData[0])
        else $error("release write of one not kept");
    a_ctrl_upper_zero: assert property (
        regRd && regAddr == REG_CTRL |=> regRdData[15:4] == 12'h000)
        else $error("unused control bits not zero");
endmodule : isc_slave_ctl_assertions

/* File: testbench/isc_i2c_master.sv */
`timescale 1ns/1ns
// ====
// bus master model, open-drain, high = released
module isc_i2c_master #(
    parameter int HALF = 500
) (
    // resolved lines
    input wire logic sclLine,
    input wire logic sdaLine,
    // master pulls
    output logic mstScl,
    output logic mstSda
);
    initial begin
        mstScl = 1'b1;
        mstSda = 1'b1;
    end
    // one bit; waits while the slave stretches the clock
    task automatic bitIo(input logic b, output logic s);
        #(HALF / 2);
        mstSda = b;
        #(HALF / 2);
        mstScl = 1'b1;
        wait (sclLine === 1'b1);
        #(HALF / 2);
        s = sdaLine;
        #(HALF / 2);
        mstScl = 1'b0;
    endtask : bitIo
    // start or repeated start
    task automatic start();
        #(HALF / 2);
        mstSda = 1'b1;
        #(HALF / 2);
        mstScl = 1'b1;
        wait (sclLine === 1'b1);
        #(HALF / 2);
        mstSda = 1'b0;
        #(HALF / 2);
        mstScl = 1'b0;
    endtask : start
    // stop, clock then stands high
    task automatic stop();
        #(HALF / 2);
        mstSda = 1'b0;
        #(HALF / 2);
        mstScl = 1'b1;
        wait (sclLine === 1'b1);
        #(HALF / 2);
        mstSda = 1'b1;
        #(HALF);
    endtask : stop
    // msb first, ack line returned
    task automatic writeByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], ack);
        end
        bitIo(1'b1, ack);
    endtask : writeByte
    task automatic readByte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, b[i]);
        end
        bitIo(nack, s);
    endtask : readByte
endmodule : isc_i2c_master

/* File: testbench/isc_slave_ctl_tb.sv */
`timescale 1ns/1ns
// ====
// testbench top
module isc_slave_ctl_tb
    import isc_pkg::*;
;
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData;
    logic sclOut, sclOeN, sdaOut, sdaOeN, mstScl, mstSda, ack;
    logic [7:0] rb;
    wire logic sclLine;
    wire logic sdaLine;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    // wired-and bus lines with pull-ups
    assign sclLine = mstScl & (sclOeN | sclOut);
    assign sdaLine = mstSda & (sdaOeN | sdaOut);
    always #25 ref_clk = ~ref_clk;
    isc_slave_ctl isc_slave_ctl_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .sclClk(sclLine), .sclIn(sclLine), .sclOut(sclOut),
        .sclOeN(sclOeN), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
    isc_i2c_master mst (.sclLine(sclLine), .sdaLine(sdaLine), .mstScl(mstScl),
        .mstSda(mstSda));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic regWrite(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic readCheck(input logic [1:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask : readCheck
    // wait for the slave to hold the clock
    task automatic waitHold();
        for (int i = 0; i < 400 && sclOeN !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        check({15'h0000, sclOeN}, 16'h0000);
    endtask : waitHold
    // address-only frame
    task automatic frame(input logic [7:0] a, input logic expAck);
        mst.start();
        mst.writeByte(a, ack);
        check({15'h0000, ack}, {15'h0000, expAck});
        mst.stop();
    endtask : frame
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        readCheck(REG_CTRL, 16'h0001);
        readCheck(REG_STATUS, 16'h0000);
        regWrite(REG_CTRL, 16'h0000);
        readCheck(REG_CTRL, 16'h0001);
        regWrite(REG_CTRL, 16'hfff2);
        readCheck(REG_CTRL, 16'h0003);
        regWrite(REG_CTRL, 16'h0002);
        readCheck(REG_CTRL, 16'h0002);
        regWrite(REG_CTRL, 16'h0003);
        readCheck(REG_CTRL, 16'h0003);
        // seven-bit receive, clock held after the byte
        regWrite(REG_OWN_ADDR, 16'h0052);
        #13;
        frame(8'ha6, 1'b1);
        mst.start();
        mst.writeByte(8'ha4, ack);
        check({15'h0000, ack}, 16'h0000);
        mst.writeByte(8'h5a, ack);
        fork
            mst.stop();
            begin
                waitHold();
                readCheck(REG_CTRL, 16'h0002);
                readCheck(REG_STATUS, 16'h0023);
                readCheck(REG_DATA, 16'h005a);
                regWrite(REG_CTRL, 16'h0003);
            end
        join
        // transmit with stretching off still holds first
        regWrite(REG_CTRL, 16'h0001);
        regWrite(REG_DATA, 16'h003c);
        mst.start();
        mst.writeByte(8'ha5, ack);
        check({15'h0000, ack}, 16'h0000);
        fork
            mst.readByte(1'b1, rb);
            begin
                waitHold();
                readCheck(REG_CTRL, 16'h0000);
                readCheck(REG_STATUS, 16'h0026);
                regWrite(REG_CTRL, 16'h0001);
            end
        join
        check({8'h00, rb}, 16'h003c);
        mst.stop();
        // ten-bit address
        regWrite(REG_OWN_ADDR, 16'h02a7);
        regWrite(REG_CTRL, 16'h0009);
        mst.start();
        mst.writeByte(8'hf4, ack);
        check({15'h0000, ack}, 16'h0000);
        mst.writeByte(8'ha7, ack);
        check({15'h0000, ack}, 16'h0000);
        mst.writeByte(8'h11, ack);
        mst.stop();
        readCheck(REG_DATA, 16'h0011);
        frame(8'h4e, 1'b1);
        // accept-all on, then off
        regWrite(REG_CTRL, 16'h0005);
        frame(8'h20, 1'b0);
        regWrite(REG_CTRL, 16'h0001);
        frame(8'h20, 1'b1);
        stop_test();
    end
endmodule : isc_slave_ctl_tb
bind isc_slave_ctl isc_slave_ctl_assertions isc_slave_ctl_assertions_inst (.ref_clk(ref_clk),
    .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .sclClk(sclClk), .sclIn(sclIn), .sclOut(sclOut),
    .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
